/* dsp_asserts.sv */
module dsp_asserts (
  input logic        clk, rst_n, ce, wr_en, data_oe, edge_bank, capt_valid, top_locked,
  input logic [15:0] clk_pins,
  input logic [1:0]  top_ref_sel, group_mode,
  input logic [31:0] wr_data, data_out, capt_data,
  input logic [5:0]  top_tap
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [9:0] refs_r;
  logic       ref_d_r;
  // counts selected reference rises until lock
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      refs_r <= 10'h0;
      ref_d_r <= 1'b0;
    end
    else
    begin
      ref_d_r <= clk_pins[{2'h3, top_ref_sel}];
      if (clk_pins[{2'h3, top_ref_sel}] && !ref_d_r && !top_locked && refs_r != 10'h3ff)
        refs_r <= refs_r + 10'h1;
    end
  function automatic logic [31:0] msk(input logic [1:0] m);
    return m == 2'h1 ? 32'hffff : (m == 2'h2 ? 32'hffffffff : 32'hff);
  endfunction
  sequence side_steady;
    (!edge_bank && ce)[*4];
  endsequence
  chk_side_capture: assert property (side_steady |-> capt_valid)
    else $error("side bank missed capture");
  chk_no_early: assert property (edge_bank && $past(edge_bank) && !$past(top_locked) |-> !capt_valid)
    else $error("capture before lock");
  chk_lock_sticky: assert property (top_locked |=> top_locked)
    else $error("lock dropped");
  chk_lock_bound: assert property (refs_r > 10'h102 |-> top_locked)
    else $error("lock too slow");
  chk_tap_step: assert property ($changed(top_tap) |->
    top_tap == $past(top_tap) + 6'h01 || top_tap == $past(top_tap) - 6'h01)
    else $error("tap jumped");
  chk_oe_follow: assert property ($past(ce) |-> data_oe == $past(wr_en))
    else $error("oe timing wrong");
  chk_wr_mask: assert property ($past(ce) |-> data_out == ($past(wr_data) & msk($past(group_mode))))
    else $error("write data mask wrong");
  chk_cap_width: assert property ($stable(group_mode) && capt_valid |->
    (capt_data & ~msk(group_mode)) == 32'h0)
    else $error("capture wider than group");
endmodule
bind dsp_strobe_shift dsp_asserts u_chk (.*);

/* dsp_consts.vh */
`ifndef DSP_CONSTS_VH
`define DSP_CONSTS_VH
// strobe groups per edge
`define DSP_NUM_STROBES     10
// delay-chain tap select width (one tap = one system clock, up to 2^width taps)
`define DSP_TAP_W           6
`define DSP_TAP_FULL        7'h40
// phase setting width: fraction of a cycle in 1/64 steps
`define DSP_PHASE_W         6
// lock settle bound in reference cycles
`define DSP_LOCK_CYCLES     256
`define DSP_LOCK_CNT_W      9
// data group width modes
`define DSP_MODE_X8         2'h0
`define DSP_MODE_X16        2'h1
`define DSP_MODE_X32        2'h2
`define DSP_DATA_W          32
// bank selectors
`define DSP_BANK_EDGE       1'h1
// top edge reference clock select width (one of four inputs)
`define DSP_REF_SEL_W       2
// reset value of the tap counter
`define DSP_TAP_RESET       6'h00
`endif

/* dsp_edge_ref.v */
`include "dsp_consts.vh"
// one edge reference circuit: phase detector, up/down counter, delay select
module dsp_edge_ref (
  // clock and reset
  input  wire                        clk,
  input  wire                        rst_n,
  input  wire                        ce,
  // reference clock edges, already synchronised
  input  wire                        ref_rise,
  // requested phase, in 1/64 cycle steps
  input  wire [`DSP_PHASE_W-1:0]     phase_set,
  // selects the tap of the strobe 0 delay line
  output reg  [`DSP_TAP_W-1:0]       tap_sel_r,
  output reg                         locked_r
);
  // period measured in system clocks between reference edges
  reg  [`DSP_TAP_W:0]      per_cnt_r;
  reg  [`DSP_TAP_W:0]      period_r;
  reg  [`DSP_LOCK_CNT_W-1:0] ref_cnt_r;
  wire [`DSP_TAP_W+`DSP_PHASE_W:0] prod;
  wire [`DSP_TAP_W-1:0]    target;

  // delayed reference position compared with requested position
  assign prod   = period_r * phase_set;
  assign target = prod[`DSP_TAP_W+`DSP_PHASE_W-1:`DSP_PHASE_W];

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      per_cnt_r <= 7'h00;
      period_r  <= 7'h00;
      ref_cnt_r <= 9'h000;
      tap_sel_r <= `DSP_TAP_RESET;
      locked_r  <= 1'b0;
    end
    else if (ce)
    begin
      if (ref_rise)
      begin
        per_cnt_r <= 7'h01;
        period_r  <= per_cnt_r;
        // phase comparator steps the up/down counter
        if (tap_sel_r < target)
          tap_sel_r <= tap_sel_r + 6'h01;
        else if (tap_sel_r > target)
          tap_sel_r <= tap_sel_r - 6'h01;
        if (ref_cnt_r != 9'h1ff)
          ref_cnt_r <= ref_cnt_r + 9'h001;
        // settled by the bound at the latest
        if ((tap_sel_r == target && period_r != 7'h00) ||
            ref_cnt_r >= 9'h0ff)
          locked_r <= 1'b1;
      end
      else if (per_cnt_r != `DSP_TAP_FULL)
        per_cnt_r <= per_cnt_r + 7'h01;
    end
  end
endmodule

/* dsp_mem_model.sv */
module dsp_mem_model (
  output logic [9:0]  strobe,
  output logic [31:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    strobe = 10'h0;
    dq = 32'h0;
  end
  // data leads by 150, all ten strobes rise a quarter into the window, fall 450 later, then data driven to its inverse
  task automatic burst(input logic [31:0] d);
    dq = d;
    #150 strobe = 10'h3ff;
    #450 strobe = 10'h0;
    dq = ~d;
  endtask
endmodule

/* dsp_strobe_shift.v */
`include "dsp_consts.vh"
module dsp_strobe_shift (
  // clock and reset
  input  wire                          clk,
  input  wire                          rst_n,
  input  wire                          ce,
  // clock inputs: [7:4] lower group, [15:12] upper group
  input  wire [15:0]                   clk_pins,
  input  wire [1:0]                    top_ref_sel,
  input  wire [1:0]                    bot_ref_sel,
  // phase settings per edge
  input  wire [`DSP_PHASE_W-1:0]       top_phase,
  input  wire [`DSP_PHASE_W-1:0]       bot_phase,
  // bank placement: 1 = top/bottom edge bank, 0 = side bank
  input  wire                          edge_bank,
  input  wire [1:0]                    group_mode,
  // strobes and data from the memory
  input  wire [`DSP_NUM_STROBES-1:0]   top_strobe,
  input  wire [`DSP_NUM_STROBES-1:0]   bot_strobe,
  input  wire [`DSP_DATA_W-1:0]        data_in,
  // write path
  input  wire [`DSP_DATA_W-1:0]        wr_data,
  input  wire                          wr_en,
  output reg  [`DSP_DATA_W-1:0]        data_out,
  output reg                           data_oe,
  // results
  output reg  [`DSP_DATA_W-1:0]        capt_data,
  output reg                           capt_valid,
  output wire [`DSP_TAP_W-1:0]         top_tap,
  output wire [`DSP_TAP_W-1:0]         bot_tap,
  output wire                          top_locked,
  output wire                          bot_locked
);
  // reference clock synchronisers and edge finders
  reg  [1:0] top_ref_s_r;
  reg  [1:0] bot_ref_s_r;
  reg        top_ref_d_r;
  reg        bot_ref_d_r;
  wire       top_rise;
  wire       bot_rise;
  // strobe synchronisers and delay lines
  reg  [`DSP_NUM_STROBES-1:0] top_s1_r;
  reg  [`DSP_NUM_STROBES-1:0] top_s2_r;
  reg  [`DSP_NUM_STROBES-1:0] bot_s1_r;
  reg  [`DSP_NUM_STROBES-1:0] bot_s2_r;
  reg  [`DSP_DATA_W-1:0]      din_s1_r;
  reg  [`DSP_DATA_W-1:0]      din_s2_r;
  reg  [(`DSP_TAP_FULL)-1:0]  top_line_r;
  reg  [(`DSP_TAP_FULL)-1:0]  bot_line_r;
  wire [`DSP_NUM_STROBES-1:0] bot_dly;
  reg                         strobe_prev_r;
  wire [`DSP_NUM_STROBES-1:0] top_dly;
  wire                        bus_strobe;
  wire                        bus_rise;
  reg  [`DSP_DATA_W-1:0]      group_mask;
  reg                         oe_r;
  reg                         oe_neg_r;

  // group width decode
  function [`DSP_DATA_W-1:0] mode_mask;
    input [1:0] mode;
    begin
      case (mode)
        `DSP_MODE_X8:  mode_mask = 32'h000000ff;
        `DSP_MODE_X16: mode_mask = 32'h0000ffff;
        `DSP_MODE_X32: mode_mask = 32'hffffffff;
        default:       mode_mask = 32'h000000ff;
      endcase
    end
  endfunction

  always @*
  begin
    group_mask = mode_mask(group_mode);
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      top_ref_s_r <= 2'h0;
      bot_ref_s_r <= 2'h0;
      top_ref_d_r <= 1'b0;
      bot_ref_d_r <= 1'b0;
      top_s1_r    <= 10'h000;
      top_s2_r    <= 10'h000;
      bot_s1_r    <= 10'h000;
      bot_s2_r    <= 10'h000;
      din_s1_r    <= 32'h00000000;
      din_s2_r    <= 32'h00000000;
    end
    else if (ce)
    begin
      top_ref_s_r <= {top_ref_s_r[0], clk_pins[4'hc + {2'h0, top_ref_sel}]};
      bot_ref_s_r <= {bot_ref_s_r[0], clk_pins[4'h4 + {2'h0, bot_ref_sel}]};
      top_ref_d_r <= top_ref_s_r[1];
      bot_ref_d_r <= bot_ref_s_r[1];
      top_s1_r    <= top_strobe;
      top_s2_r    <= top_s1_r;
      bot_s1_r    <= bot_strobe;
      bot_s2_r    <= bot_s1_r;
      din_s1_r    <= data_in;
      din_s2_r    <= din_s1_r;
    end
  end

  assign top_rise = top_ref_s_r[1] & ~top_ref_d_r;
  assign bot_rise = bot_ref_s_r[1] & ~bot_ref_d_r;

  // independent reference circuit per edge
  dsp_edge_ref u_top (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .ref_rise  (top_rise),
    .phase_set (top_phase),
    .tap_sel_r (top_tap),
    .locked_r  (top_locked)
  );

  dsp_edge_ref u_bot (
    .clk       (clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .ref_rise  (bot_rise),
    .phase_set (bot_phase),
    .tap_sel_r (bot_tap),
    .locked_r  (bot_locked)
  );

  // tapped delay of strobe 0 per edge, each edge on its own tap
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      top_line_r <= 64'h0;
      bot_line_r <= 64'h0;
    end
    else if (ce)
    begin
      top_line_r <= {top_line_r[62:0], top_s2_r[0]};
      bot_line_r <= {bot_line_r[62:0], bot_s2_r[0]};
    end
  end

  genvar g;
  generate
    for (g = 0; g < `DSP_NUM_STROBES; g = g + 1)
    begin : g_dly
      // tap applied to strobe 0 only; strobes 1 to 9 pass undelayed
      assign top_dly[g] = (g == 0) ? top_line_r[top_tap] : top_s2_r[g];
      assign bot_dly[g] = (g == 0) ? bot_line_r[bot_tap] : bot_s2_r[g];
    end
  endgenerate

  // local strobe bus, separate from the system clock tree
  assign bus_strobe = top_dly[0] | bot_dly[0];
  assign bus_rise   = bus_strobe & ~strobe_prev_r;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_prev_r <= 1'b0;
      capt_data     <= 32'h00000000;
      capt_valid    <= 1'b0;
      data_out      <= 32'h00000000;
      oe_r          <= 1'b0;
    end
    else if (ce)
    begin
      strobe_prev_r <= bus_strobe;
      capt_valid    <= 1'b0;
      if (edge_bank == `DSP_BANK_EDGE)
      begin
        // strobe-clocked capture only with phase-shift circuitry
        if (bus_rise && top_locked && bot_locked)
        begin
          capt_data  <= din_s2_r & group_mask;
          capt_valid <= 1'b1;
        end
      end
      else
      begin
        // side bank: read strobe ignored
        capt_data  <= din_s2_r & group_mask;
        capt_valid <= 1'b1;
      end
      // per bit: two sync stages, capture, output data, two enable stages
      data_out <= wr_data & group_mask;
      oe_r     <= wr_en;
    end
  end

  // output enable held inactive until falling edge
  always @(negedge clk or negedge rst_n)
  begin
    if (!rst_n)
      oe_neg_r <= 1'b0;
    else if (ce)
      oe_neg_r <= oe_r;
  end

  always @*
  begin
    data_oe = oe_neg_r;
  end
endmodule

/* tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER = 8; // reference period in system clocks
  logic        clk, rst_n, ce, edge_bank, wr_en, refc, data_oe, capt_valid, top_locked, bot_locked;
  logic [1:0]  gm;
  logic [9:0]  stb;
  logic [5:0]  top_tap, bot_tap;
  logic [31:0] wr_data, d, dq, data_out, capt_data;
  int          err_count, n_checks, seed, k, j;
  dsp_mem_model m (.strobe(stb), .dq(dq));
  dsp_strobe_shift dut (.clk(clk), .rst_n(rst_n), .ce(ce),
    .clk_pins({2'h0, refc, 6'h0, refc, 6'h0}), .top_ref_sel(2'h1), .bot_ref_sel(2'h2),
    .top_phase(6'h10), .bot_phase(6'h18), .edge_bank(edge_bank), .group_mode(gm),
    .top_strobe(stb), .bot_strobe(stb), .data_in(dq), .wr_data(wr_data), .wr_en(wr_en),
    .data_out(data_out), .data_oe(data_oe), .capt_data(capt_data), .capt_valid(capt_valid),
    .top_tap(top_tap), .bot_tap(bot_tap), .top_locked(top_locked), .bot_locked(bot_locked));
  function automatic logic [31:0] msk(input logic [1:0] mo);
    return mo == 2'h1 ? 32'hffff : (mo == 2'h2 ? 32'hffffffff : 32'hff);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    refc = 0;
    #7;
    forever #100 refc = ~refc;
  end
  initial
  begin
    #300us;
    err_count++;
    tally_and_finish;
  end
  initial
  begin
    seed = 32'h0a375df5;
    rst_n = 0; ce = 1; edge_bank = 1; wr_en = 0; gm = 0; wr_data = 0;
    repeat (8) @(negedge clk);
    rst_n <= 1;
    k = 0;
    fork
      m.burst($random(seed));
      repeat (26) @(negedge clk) if (capt_valid !== 1'b0) k++;
    join
    chk(k, 0);
    for (j = 0; j < 4; j++)
    begin
      gm <= j[1:0]; wr_en <= 1; wr_data <= $random(seed);
      @(negedge clk) chk(data_out, wr_data & msk(gm));
      @(negedge clk) chk(data_oe, 1);
    end
    wr_en <= 0;
    repeat (2) @(negedge clk);
    chk(data_oe, 0);
    for (k = 0; k < 2200 && !(top_locked === 1'b1 && bot_locked === 1'b1); k++) @(negedge clk);
    chk({top_locked, bot_locked}, 2'h3);
    chk(top_tap, PER * 16 / 64);
    chk(bot_tap, PER * 24 / 64);
    for (k = 0; k < 8; k++)
    begin
      edge_bank <= k < 4; gm <= k[1:0]; d = $random(seed);
      @(negedge clk);
      fork
        m.burst(d);
        begin
          if (k < 4)
            for (j = 0; j < 30 && capt_valid !== 1'b1; j++) @(negedge clk);
          else
            repeat (10) @(negedge clk);
          chk(capt_valid, 1);
          chk(capt_data, d & msk(k[1:0]));
        end
      join
    end
    tally_and_finish;
  end
endmodule
